// ==== rtl/swcp_pkg.sv ====
// Shared constants for the single-wire configuration port
package swcp_pkg;
  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CNT_W   = 16;
  localparam int CMD_W   = 8;
  localparam int DAT_W   = 9;
  // ----------------------------------------------------------------
  // Link times in microseconds, and cycle counts derived from them
  // ----------------------------------------------------------------
  localparam int T_POR_US     = 100;
  localparam int T_STAB_US    = 100;
  localparam int T_RST_US     = 480;
  localparam int T_RSTDET_US  = 240;
  localparam int T_PWAIT_US   = 30;
  localparam int T_PRES_US    = 120;
  localparam int T_PSAMP_US   = 70;
  localparam int T_LOW_US     = 6;
  localparam int T_W0_US      = 60;
  localparam int T_RSAMP_US   = 15;
  localparam int T_SLOT_US    = 70;
  localparam int T_DLY_US     = 30;
  localparam int POR_CYC      = T_POR_US * CLK_MHZ;
  localparam int STAB_CYC     = T_STAB_US * CLK_MHZ;
  localparam int RST_CYC      = T_RST_US * CLK_MHZ;
  localparam int RSTDET_CYC   = T_RSTDET_US * CLK_MHZ;
  localparam int PWAIT_CYC    = T_PWAIT_US * CLK_MHZ;
  localparam int PRES_CYC     = T_PRES_US * CLK_MHZ;
  localparam int PSAMP_CYC    = T_PSAMP_US * CLK_MHZ;
  localparam int RREC_CYC     = (T_RST_US - T_PSAMP_US) * CLK_MHZ;
  localparam int LOW_CYC      = T_LOW_US * CLK_MHZ;
  localparam int W0_CYC       = T_W0_US * CLK_MHZ;
  localparam int RSAMP_CYC    = T_RSAMP_US * CLK_MHZ;
  localparam int SLOT_CYC     = T_SLOT_US * CLK_MHZ;
  localparam int DLY_CYC      = T_DLY_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Function commands and register defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_RATIO = 8'h01;
  localparam logic [7:0] CMD_RD_RATIO = 8'ha1;
  localparam logic [7:0] CMD_WR_SRC   = 8'h02;
  localparam logic [7:0] CMD_RD_SRC   = 8'ha2;
  localparam logic [8:0] RATIO_RST    = 9'h000;
  localparam logic [8:0] SRC_RST      = 9'h034;
  // ----------------------------------------------------------------
  // Controller registers on the Avalon side
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_WDATA  = 4'h4;
  localparam logic [3:0] OFS_RDATA  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_NOPRES_BIT = 2;
endpackage : swcp_pkg

// ==== rtl/swcp_if.sv ====
// Open-drain single-wire link joining controller and device
`timescale 1ns/1ns
interface swcp_if;
  logic pullup_en;
  logic host_out;
  logic host_oe_b;
  logic dev_out;
  logic dev_oe_b;
  logic line;
  // Wired-AND with pull-up; an enabled driver pulls to its output
  assign line = pullup_en & (host_oe_b | host_out) & (dev_oe_b | dev_out);
  modport host (input line, output host_out, output host_oe_b);
  modport dev (input line, output dev_out, output dev_oe_b);
endinterface : swcp_if

// ==== rtl/swcp_device.sv ====
// Device end: strap, reset/presence, command decode and config registers
//
// Design decisions made here: the function command decode and the single-wire access to the registers.
`timescale 1ns/1ns
module swcp_device
  import swcp_pkg::*;
#(
  parameter int unsigned TIME_DIV = 1, // Shortens every link time at once
  parameter int unsigned POR_N    = swcp_pkg::POR_CYC / TIME_DIV,
  parameter int unsigned STAB_N   = swcp_pkg::STAB_CYC / TIME_DIV,
  parameter int unsigned RSTDET_N = swcp_pkg::RSTDET_CYC / TIME_DIV,
  parameter int unsigned PWAIT_N  = swcp_pkg::PWAIT_CYC / TIME_DIV,
  parameter int unsigned PRES_N   = swcp_pkg::PRES_CYC / TIME_DIV,
  parameter int unsigned DLY_N    = swcp_pkg::DLY_CYC / TIME_DIV
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // Link
  swcp_if.dev                              link,
  // Configuration seen by the oscillator core
  output logic [swcp_pkg::DAT_W-1:0]       output_ratio,
  output logic [swcp_pkg::DAT_W-1:0]       source_prescale,
  output logic                             prog_mode,
  output logic                             run_normal,
  output logic                             access_done
);
  import swcp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    D_STRAP = 4'h0,
    D_POR   = 4'h1,
    D_IDLE  = 4'h3,
    D_RSTHI = 4'h2,
    D_PWAIT = 4'h6,
    D_PRES  = 4'h7,
    D_CMD   = 4'h5,
    D_DATA  = 4'h4,
    D_DONE  = 4'hc,
    D_STAB  = 4'hd,
    D_RUN   = 4'hf
  } swcp_dstate_t;

  swcp_dstate_t     state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] lowcnt, next_lowcnt;
  logic [3:0]       bitn, next_bitn;
  logic [7:0]       cmd, next_cmd;
  logic [DAT_W-1:0] sh, next_sh;
  logic             rd, next_rd;
  logic             sel_src, next_sel_src;
  logic             in_slot, next_in_slot;
  logic             drv, next_drv;
  logic             line_q;
  logic [DAT_W-1:0] next_ratio, next_src;
  logic             next_prog, next_run, next_done;
  logic             fall, prog_live, rst_hit, bit_end;
  logic [7:0]       cmd_full;

  assign link.dev_out  = 1'b0;
  assign link.dev_oe_b = ~drv;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Edge and long-low detection on the synchronous line sample
  always_comb begin
    fall      = line_q & ~link.line;
    prog_live = (state != D_STRAP) && (state != D_POR) &&
                (state != D_STAB) && (state != D_RUN);
    rst_hit   = prog_live && !link.line && (lowcnt == CNT_W'(RSTDET_N - 1));
    bit_end   = in_slot && (cnt == CNT_W'(DLY_N - 1));
    cmd_full  = {link.line, cmd[7:1]};
    next_lowcnt = link.line ? '0 : (rst_hit ? lowcnt : lowcnt + 1'b1);
  end

  // Main sequencer
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_bitn    = bitn;
    next_cmd     = cmd;
    next_sh      = sh;
    next_rd      = rd;
    next_sel_src = sel_src;
    next_in_slot = in_slot;
    next_drv     = drv;
    next_ratio   = output_ratio;
    next_src     = source_prescale;
    next_prog    = prog_mode;
    next_run     = run_normal;
    next_done    = 1'b0;
    if (rst_hit) begin
      // A long low aborts whatever was going on; any state except D_STRAP, D_POR, D_STAB and D_RUN re-arms
      next_state   = D_RSTHI;
      next_in_slot = 1'b0;
      next_drv     = 1'b0;
    end else begin
      unique case (state)
        D_STRAP: begin
          // Strap caught at the first edge after reset release
          next_cnt = '0;
          if (link.line) begin
            next_state = D_POR;
            next_prog  = 1'b1;
            next_drv   = 1'b1;
          end else begin
            next_state = D_STAB;
          end
        end
        D_POR: begin
          next_cnt = cnt + 1'b1;
          if (cnt == CNT_W'(POR_N - 1)) begin
            next_state = D_IDLE;
            next_drv   = 1'b0;
          end
        end
        D_STAB: begin
          next_cnt = cnt + 1'b1;
          if (cnt == CNT_W'(STAB_N - 1)) begin
            next_state = D_RUN;
            next_run   = 1'b1;
          end
        end
        D_RUN: begin
          next_state = D_RUN;
        end
        D_IDLE, D_DONE: begin
          // Only a reset pulse leaves here
          next_state = state;
        end
        D_RSTHI: begin
          next_cnt = '0;
          if (link.line) begin
            next_state = D_PWAIT;
          end
        end
        D_PWAIT: begin
          next_cnt = cnt + 1'b1;
          if (cnt == CNT_W'(PWAIT_N - 1)) begin
            next_state = D_PRES;
            next_cnt   = '0;
            next_drv   = 1'b1;
          end
        end
        D_PRES: begin
          next_cnt = cnt + 1'b1;
          if (cnt == CNT_W'(PRES_N - 1)) begin
            next_state   = D_CMD;
            next_drv     = 1'b0;
            next_bitn    = '0;
            next_in_slot = 1'b0;
          end
        end
        D_CMD, D_DATA: begin
          if (!in_slot && fall) begin
            // Slot opened by the master; read zero pulls low at once
            next_in_slot = 1'b1;
            next_cnt     = '0;
            next_drv     = (state == D_DATA) && rd && !sh[0];
          end else if (in_slot) begin
            next_cnt = cnt + 1'b1;
          end
          if (bit_end) begin
            next_in_slot = 1'b0;
            next_drv     = 1'b0;
            next_bitn    = bitn + 1'b1;
            if (state == D_CMD) begin
              next_cmd = cmd_full;
              if (bitn == 4'd7) begin
                next_bitn  = '0;
                next_state = D_DATA;
                unique case (cmd_full)
                  CMD_WR_RATIO: begin
                    next_rd = 1'b0;
                    next_sel_src = 1'b0;
                  end
                  CMD_RD_RATIO: begin
                    next_rd = 1'b1;
                    next_sel_src = 1'b0;
                    next_sh = output_ratio;
                  end
                  CMD_WR_SRC: begin
                    next_rd = 1'b0;
                    next_sel_src = 1'b1;
                  end
                  CMD_RD_SRC: begin
                    next_rd = 1'b1;
                    next_sel_src = 1'b1;
                    next_sh = source_prescale;
                  end
                  default: begin
                    next_state = D_DONE; // Unknown command is ignored
                  end
                endcase
              end
            end else begin
              // Data lsb first: write shifts in, read shifts out
              next_sh = rd ? {1'b0, sh[DAT_W-1:1]} : {link.line, sh[DAT_W-1:1]};
              if (bitn == 4'(DAT_W - 1)) begin
                next_state = D_DONE;
                next_done  = 1'b1;
                if (!rd && !sel_src) begin
                  next_ratio = {link.line, sh[DAT_W-1:1]};
                end
                if (!rd && sel_src) begin
                  next_src = {link.line, sh[DAT_W-1:1]};
                end
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Defaults stand for the factory settings of both registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state           <= D_STRAP;
      cnt             <= '0;
      lowcnt          <= '0;
      bitn            <= '0;
      cmd             <= '0;
      sh              <= '0;
      rd              <= 1'b0;
      sel_src         <= 1'b0;
      in_slot         <= 1'b0;
      drv             <= 1'b0;
      line_q          <= 1'b0;
      output_ratio    <= RATIO_RST;
      source_prescale <= SRC_RST;
      prog_mode       <= 1'b0;
      run_normal      <= 1'b0;
      access_done     <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      lowcnt          <= next_lowcnt;
      bitn            <= next_bitn;
      cmd             <= next_cmd;
      sh              <= next_sh;
      rd              <= next_rd;
      sel_src         <= next_sel_src;
      in_slot         <= next_in_slot;
      drv             <= next_drv;
      line_q          <= link.line;
      output_ratio    <= next_ratio;
      source_prescale <= next_src;
      prog_mode       <= next_prog;
      run_normal      <= next_run;
      access_done     <= next_done;
    end
  end
endmodule : swcp_device

// ==== rtl/swcp_host.sv ====
// Controller end: Avalon-MM registers driving the single-wire master
`timescale 1ns/1ns
module swcp_host
  import swcp_pkg::*;
#(
  parameter int unsigned TIME_DIV = 1, // Shortens every link time at once
  parameter int unsigned RST_N   = swcp_pkg::RST_CYC / TIME_DIV,
  parameter int unsigned PSAMP_N = swcp_pkg::PSAMP_CYC / TIME_DIV,
  parameter int unsigned RREC_N  = swcp_pkg::RREC_CYC / TIME_DIV,
  parameter int unsigned LOW_N   = swcp_pkg::LOW_CYC / TIME_DIV,
  parameter int unsigned W0_N    = swcp_pkg::W0_CYC / TIME_DIV,
  parameter int unsigned RSAMP_N = swcp_pkg::RSAMP_CYC / TIME_DIV,
  parameter int unsigned SLOT_N  = swcp_pkg::SLOT_CYC / TIME_DIV
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link
  swcp_if.host             link
);
  import swcp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_RST   = 3'h1,
    H_PWAIT = 3'h3,
    H_RREC  = 3'h2,
    H_SLOT  = 3'h6
  } swcp_hstate_t;

  swcp_hstate_t     state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [4:0]       bitn, next_bitn;
  logic [7:0]       cmd_r, next_cmd_r;
  logic [DAT_W-1:0] wdata_r, next_wdata_r;
  logic [DAT_W-1:0] rdata_r, next_rdata_r;
  logic [DAT_W-1:0] rsh, next_rsh;
  logic [16:0]      osh, next_osh;
  logic             busy, next_busy;
  logic             done, next_done;
  logic             nopres, next_nopres;
  logic             drv, next_drv;
  logic [31:0]      next_readdata;
  logic             next_wait;
  logic             take, start, rd_data;
  logic [CNT_W-1:0] lowlen;

  assign link.host_out  = 1'b0;
  assign link.host_oe_b = ~drv;

  // ----------------------------------------------------------------
  // Bus slave: one wait state, then the request is taken
  // ----------------------------------------------------------------
  always_comb begin
    take      = (avs_read | avs_write) & ~avs_waitrequest;
    start     = take & avs_write & (avs_address == OFS_CTRL) & ~busy;
    next_wait = ~((avs_read | avs_write) & avs_waitrequest);
    next_readdata = avs_readdata;
    if ((avs_read | avs_write) & avs_waitrequest) begin
      unique case (avs_address)
        OFS_CTRL:   next_readdata = {24'h000000, cmd_r};
        OFS_WDATA:  next_readdata = {23'h00000, wdata_r};
        OFS_RDATA:  next_readdata = {23'h00000, rdata_r};
        OFS_STATUS: next_readdata = {29'h0000000, nopres, done, busy};
        default:    next_readdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer: reset, presence, then 8 + 9 slots
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_bitn    = bitn;
    next_cmd_r   = cmd_r;
    next_wdata_r = wdata_r;
    next_rdata_r = rdata_r;
    next_rsh     = rsh;
    next_osh     = osh;
    next_busy    = busy;
    next_done    = done;
    next_nopres  = nopres;
    next_drv     = drv;
    rd_data      = cmd_r[7] && (bitn > 5'd7);
    // Write zero holds low most of the slot, everything else briefly
    lowlen = (!rd_data && !osh[0]) ? CNT_W'(W0_N) : CNT_W'(LOW_N);
    if (take && avs_write && avs_address == OFS_WDATA && !busy) begin
      next_wdata_r = avs_writedata[DAT_W-1:0];
    end
    unique case (state)
      H_IDLE: begin
        if (start) begin
          next_cmd_r = avs_writedata[7:0];
          next_busy  = 1'b1;
          next_done  = 1'b0;
          next_state = H_RST;
          next_cnt   = '0;
          next_drv   = 1'b1;
        end
      end
      H_RST: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(RST_N - 1)) begin
          next_state = H_PWAIT;
          next_cnt   = '0;
          next_drv   = 1'b0;
        end
      end
      H_PWAIT: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(PSAMP_N - 1)) begin
          next_nopres = link.line;
          next_state  = H_RREC;
          next_cnt    = '0;
        end
      end
      H_RREC: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(RREC_N - 1)) begin
          next_cnt = '0;
          if (nopres) begin
            next_state = H_IDLE;
            next_busy  = 1'b0;
            next_done  = 1'b1;
          end else begin
            next_state = H_SLOT;
            next_bitn  = '0;
            next_osh   = {wdata_r, cmd_r};
            next_drv   = 1'b1;
          end
        end
      end
      H_SLOT: begin
        next_cnt = cnt + 1'b1;
        next_drv = (cnt + 1'b1) < lowlen;
        if (rd_data && cnt == CNT_W'(RSAMP_N - 1)) begin
          next_rsh = {link.line, rsh[DAT_W-1:1]};
        end
        if (cnt == CNT_W'(SLOT_N - 1)) begin
          next_cnt  = '0;
          next_osh  = {1'b0, osh[16:1]};
          next_bitn = bitn + 1'b1;
          next_drv  = 1'b1;
          if (bitn == 5'd16) begin
            next_state = H_IDLE;
            next_drv   = 1'b0;
            next_busy  = 1'b0;
            next_done  = 1'b1;
            if (cmd_r[7]) begin
              next_rdata_r = rsh;
            end
          end
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state           <= H_IDLE;
      cnt             <= '0;
      bitn            <= '0;
      cmd_r           <= '0;
      wdata_r         <= '0;
      rdata_r         <= '0;
      rsh             <= '0;
      osh             <= '0;
      busy            <= 1'b0;
      done            <= 1'b0;
      nopres          <= 1'b0;
      drv             <= 1'b0;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      bitn            <= next_bitn;
      cmd_r           <= next_cmd_r;
      wdata_r         <= next_wdata_r;
      rdata_r         <= next_rdata_r;
      rsh             <= next_rsh;
      osh             <= next_osh;
      busy            <= next_busy;
      done            <= next_done;
      nopres          <= next_nopres;
      drv             <= next_drv;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_wait;
    end
  end
endmodule : swcp_host

// ==== test/swcp_link_assertions.sv ====
// Concurrent checks on the open-drain link between controller and device
`timescale 1ns/1ns
module swcp_link_assertions #(
  parameter int unsigned POR_N  = 50,
  parameter int unsigned PRES_N = 120,
  parameter int unsigned RST_N  = 480,
  parameter int unsigned LOW_N  = 6,
  parameter int unsigned W0_N   = 60,
  parameter int unsigned SLOT_N = 70,
  parameter int unsigned DLY_N  = 30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link signals
  input wire logic pullup_en,
  input wire logic host_out,
  input wire logic host_oe_b,
  input wire logic dev_out,
  input wire logic dev_oe_b,
  input wire logic line
);
  logic [15:0] host_cnt, dev_cnt, gap, since, next_host_cnt, next_dev_cnt, next_gap, next_since;
  logic [4:0]  slots, next_slots;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Low run lengths, slot spacing, slots since the last reset pulse; spacing and power-up time saturate so idle never wraps
  always_comb begin
    next_host_cnt = host_oe_b ? 16'h0000 : host_cnt + 16'h0001;
    next_dev_cnt  = dev_oe_b ? 16'h0000 : dev_cnt + 16'h0001;
    next_gap      = (!host_oe_b && host_cnt == 16'h0000) ? 16'h0001 : gap + {15'h000, gap != 16'hffff};
    next_since    = since + {15'h000, since != 16'hffff};
    next_slots    = slots;
    if (host_oe_b && host_cnt == 16'(RST_N)) begin
      next_slots = 5'h00;
    end else if (host_oe_b && host_cnt != 16'h0000) begin
      next_slots = slots + 5'h01;
    end
  end
  // Register the helper state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_cnt <= 16'h0000;
      dev_cnt  <= 16'h0000;
      gap      <= 16'hffff;
      since    <= 16'h0000;
      slots    <= 5'h00;
    end else begin
      host_cnt <= next_host_cnt;
      dev_cnt  <= next_dev_cnt;
      gap      <= next_gap;
      since    <= next_since;
      slots    <= next_slots;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  host_zero_a: assert property (!host_oe_b |-> !host_out)
    else $error("controller drives a high level on the line");
  host_pulse_a: assert property ($rose(host_oe_b) |-> host_cnt == 16'(LOW_N) || host_cnt == 16'(W0_N) || host_cnt == 16'(RST_N))
    else $error("controller low pulse has a wrong length");
  dev_pulse_a: assert property ($rose(dev_oe_b) |-> dev_cnt == 16'(POR_N) || dev_cnt == 16'(PRES_N) || dev_cnt <= 16'(DLY_N))
    else $error("device low pulse has a wrong length");
  presence_a: assert property ($rose(host_oe_b) && host_cnt == 16'(RST_N) |-> ##[1:40] (!dev_oe_b)[*8])
    else $error("no presence pulse after a reset pulse");
  slot_gap_a: assert property (!host_oe_b && host_cnt == 16'h0000 |-> gap >= 16'(SLOT_N))
    else $error("slots opened too close together");
  slot_count_a: assert property (slots <= 5'd17)
    else $error("more than seventeen slots after one reset pulse");
  por_start_a: assert property (since == 16'h0003 |-> dev_oe_b == !pullup_en)
    else $error("device strap response wrong after power-up");
  por_hold_a: assert property ($rose(dev_oe_b) && since < 16'h0064 |-> dev_cnt == 16'(POR_N))
    else $error("device power-up hold has a wrong length");
  strap_low_a: assert property (!pullup_en |-> dev_oe_b && !dev_out)
    else $error("device drives the line outside programming mode");
  // Main scenarios reached
  cover property ($rose(host_oe_b) && host_cnt == 16'(W0_N));
  cover property (slots == 5'd17 && line);
  cover property ($rose(dev_oe_b) && dev_cnt <= 16'(DLY_N));
endmodule : swcp_link_assertions

// ==== test/tb_single_wire_config_port.sv ====
// Self-checking bench: controller and device joined over the link
`timescale 1ns/1ns
module tb_single_wire_config_port;
  import swcp_pkg::*;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic        prog_mode, run_normal, access_done;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, st, rd;
  logic [8:0]  output_ratio, source_prescale;
  int          n_fail, cmp_count, n_done;
  swcp_if swcp_if_i ();
  swcp_host #(.TIME_DIV(100)) swcp_host_i (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(swcp_if_i));
  swcp_device #(.TIME_DIV(100), .POR_N(50), .STAB_N(50))
    swcp_device_i (.clk(clk), .rst_b(rst_b), .link(swcp_if_i), .output_ratio(output_ratio),
    .source_prescale(source_prescale), .prog_mode(prog_mode), .run_normal(run_normal),
    .access_done(access_done));
  swcp_link_assertions swcp_link_assertions_i (.clk(clk), .rst_b(rst_b),
    .pullup_en(swcp_if_i.pullup_en), .host_out(swcp_if_i.host_out),
    .host_oe_b(swcp_if_i.host_oe_b), .dev_out(swcp_if_i.dev_out),
    .dev_oe_b(swcp_if_i.dev_oe_b), .line(swcp_if_i.line));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Completed data phases seen by the device
  always @(posedge clk) begin
    if (access_done === 1'b1) n_done++;
  end
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
  endtask : bus
  // Full link access: data, command, poll busy, fetch read data
  task automatic xfer(input logic [7:0] cmd, input logic [8:0] wd);
    int i;
    bus(1'b1, OFS_WDATA, {23'h0, wd}, rd);
    bus(1'b1, OFS_CTRL, {24'h0, cmd}, rd);
    for (i = 0; i < 1000; i++) begin
      bus(1'b0, OFS_STATUS, 32'h0, st);
      if (st[ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 1000) begin
      n_fail++;
      print_verdict();
    end
    bus(1'b0, OFS_RDATA, 32'h0, rd);
  endtask : xfer
  task automatic do_reset(input logic pu);
    rst_b               <= 1'b0;
    swcp_if_i.pullup_en <= pu;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (60) @(posedge clk);
  endtask : do_reset
  task automatic t_defaults();
    check("prog_mode", prog_mode, 1'b1);
    check("run_normal", run_normal, 1'b0);
    bus(1'b0, 4'h2, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    xfer(8'ha1, 9'h000);
    check("ratio default", rd[8:0], 9'h000);
    xfer(8'ha2, 9'h000);
    check("source default", rd[8:0], 9'h034);
    check("prescaler bypass", rd[5], 1'b1);
    check("status", st[2:0], 3'b010);
    $display("t_defaults done");
  endtask : t_defaults
  task automatic t_write_read();
    logic [8:0] val [2] = '{9'h1a5, 9'h14b};
    for (int k = 0; k < 2; k++) begin
      xfer(k ? 8'h02 : 8'h01, val[k]);
      check("ratio", output_ratio, 9'h1a5);
      check("source", source_prescale, k ? 9'h14b : 9'h034);
      xfer(k ? 8'ha2 : 8'ha1, 9'h000);
      check("readback", rd[8:0], val[k]);
      check("done count", n_done, 4 + 2 * k);
    end
    $display("t_write_read done");
  endtask : t_write_read
  task automatic t_bad_cmd();
    xfer(8'h55, 9'h0ff);
    check("ratio kept", output_ratio, 9'h1a5);
    check("source kept", source_prescale, 9'h14b);
    check("no data phase", n_done, 6);
    xfer(8'ha1, 9'h000);
    check("read after abort", rd[8:0], 9'h1a5);
    $display("t_bad_cmd done");
  endtask : t_bad_cmd
  task automatic t_strap_low();
    rst_b               <= 1'b0;
    swcp_if_i.pullup_en <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (45) @(posedge clk);
    check("stabilizing", run_normal, 1'b0);
    repeat (15) @(posedge clk);
    check("normal run", run_normal, 1'b1);
    check("no programming", prog_mode, 1'b0);
    check("line left free", swcp_if_i.dev_oe_b, 1'b1);
    do_reset(1'b1);
    check("programming again", prog_mode, 1'b1);
    $display("t_strap_low done");
  endtask : t_strap_low
  // Main sequence
  initial begin
    n_fail = 0;
    cmp_count = 0;
    n_done = 0;
    avs_address   <= 4'h0;
    avs_writedata <= 32'h0;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    do_reset(1'b1);
    t_defaults();
    t_write_read();
    t_bad_cmd();
    t_strap_low();
    print_verdict();
  end
endmodule : tb_single_wire_config_port
